// ---- verilog/tpss_map.svh ----
// constants for the thermal position sequencer: register map, fields, resets, timing
// assumes a 100 MHz pclk and 32-bit apb data
`ifndef TPSS_MAP_SVH
`define TPSS_MAP_SVH

// ==========================================
// register offsets (byte addresses)
`define TPSS_ADDR_CTRL 12'h000
`define TPSS_ADDR_RESTART 12'h004
`define TPSS_ADDR_STATUS 12'h008

// ==========================================
// control register fields
`define TPSS_CTRL_AUTO 0
`define TPSS_CTRL_MANPOS_LO 1
`define TPSS_CTRL_MANPOS_HI 3
`define TPSS_CTRL_SRC_EXT 4
`define TPSS_CTRL_ONTIME_LO 8
`define TPSS_CTRL_ONTIME_HI 11
`define TPSS_CTRL_RATE_LO 12
`define TPSS_CTRL_RATE_HI 15
`define TPSS_CTRL_MASK 32'h0000ff1f
`define TPSS_CTRL_RESET 32'h00001100

// ==========================================
// status register fields
`define TPSS_STAT_SEL_LO 0
`define TPSS_STAT_SEL_HI 5
`define TPSS_STAT_GATE 8
`define TPSS_STAT_POS_LO 12
`define TPSS_STAT_POS_HI 14
`define TPSS_STAT_MIN_LO 16
`define TPSS_STAT_MIN_HI 19
`define TPSS_STAT_TENS_LO 20
`define TPSS_STAT_TENS_HI 23
`define TPSS_STAT_ONFF 24

// ==========================================
// timing
`define TPSS_CLK_PERIOD_NS 10
`define TPSS_TRIG_WIDTH_NS 2000
`define TPSS_TRIG_CYCLES ((`TPSS_TRIG_WIDTH_NS + `TPSS_CLK_PERIOD_NS - 1) / `TPSS_CLK_PERIOD_NS)
`define TPSS_LINE_HZ 60
`define TPSS_SEC_PER_MIN 60
`define TPSS_PRESCALE_DIV (`TPSS_LINE_HZ * `TPSS_SEC_PER_MIN)
`define TPSS_PRESCALE_BITS 14
`define TPSS_DECADE 10
`define TPSS_POSITIONS 6

`endif

// ---- verilog/tpss_pkg.sv ----
// types shared by the thermal position sequencer and its trigger pulse stretcher
// assumes nothing of its surroundings
package tpss_pkg;

    // ==========================================
    // one driver group: four trigger lines
    typedef struct packed {
        logic upper_heat;
        logic lower_heat;
        logic upper_cool;
        logic lower_cool;
    } tpss_trig_t;

    // ==========================================
    // apb answer carried together
    typedef struct packed {
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } tpss_apb_rsp_t;

    typedef enum logic [1:0] {
        TPSS_MODE_MANUAL = 2'b01,
        TPSS_MODE_AUTO = 2'b10
    } tpss_mode_t;

endpackage

// ---- verilog/tpss_pulse_stretch.sv ----
// four-channel trigger pulse stretcher: a one-cycle fire makes a fixed-width pulse
// assumes fires are already edge-detected and qualified; a new fire restarts the width
`timescale 1ns/1ps
`include "tpss_map.svh"
module tpss_pulse_stretch
    import tpss_pkg::*;
#(
    parameter int WIDTH_CYCLES = `TPSS_TRIG_CYCLES,
    parameter int CNT_BITS = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire tpss_trig_t fire,
    output tpss_trig_t pulse
);

    localparam logic [CNT_BITS-1:0] LOAD = CNT_BITS'(WIDTH_CYCLES);
    logic [3:0] fire_bits;
    logic [3:0][CNT_BITS-1:0] remain;
    logic [3:0] pulse_bits;

    assign fire_bits = fire;
    assign pulse = pulse_bits;

    // ==========================================
    // per-channel width counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remain <= '0;
            pulse_bits <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (fire_bits[i]) begin
                    remain[i] <= LOAD - 1'b1;
                    pulse_bits[i] <= 1'b1;
                end else if (remain[i] != '0) begin
                    remain[i] <= remain[i] - 1'b1;
                    pulse_bits[i] <= 1'b1;
                end else begin
                    pulse_bits[i] <= 1'b0;
                end
            end
        end
    end

endmodule

// ---- verilog/tpss_sequencer.sv ----
// thermal position sequencer and trigger steering: minute timebase, on-time and
// rate counters, six-state position counter, manual override, and routing of the
// four comparator edges to the selected position's driver group
// assumes all inputs synchronous to pclk; apb master per the amba protocol
//
// Notes on behaviour
// - each comparator rising edge makes a 2 us trigger pulse on its line
// - six active-high position selects, one per module assembly
// - active select drives both bridge switch controls low, enables driver group
// - twenty-four trigger drivers: six groups of four, heat and cool, upper and lower
// - comparator pulses reach all groups; only the selected group passes them
// - cool trigger fires the cooling switch on either phase, full wave
// - heat trigger allowed only in the half cycle when its phase is negative
// - never heat and cool trigger for one element within one half cycle
// - manual mode takes selects straight from the manual position selector
// - on-time 1 to 10 minutes, interval 10 to 100 minutes, programmable
// - timebase is the squared 60 Hz line or an external check-out clock
// - prescaler divides timebase to exactly one pulse per minute
// - minute decade counter decoded; on-time setting picks the ending state
// - on-time flop set at minute zero, cleared at the selected state
// - tens counter advances at minute zero, reset by the rate setting state
// - rate window and on-time flop ANDed into the gated enable
// - gated enable advances six-state position counter; decodes ANDed with it
// - manual selection holds continuously and follows selector changes at once
// - sequencer restart returns to position one with it selected at once
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "tpss_map.svh"
module tpss_sequencer
    import tpss_pkg::*;
#(
    parameter int PRESCALE_DIV = `TPSS_PRESCALE_DIV,
    parameter int TRIG_CYCLES = `TPSS_TRIG_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire logic line_60hz,
    input wire logic check_clock,
    input wire tpss_trig_t comparator,
    input wire logic supply_phase_positive,
    output logic [5:0] position_select,
    output logic [5:0] bridge_switch_upper_n,
    output logic [5:0] bridge_switch_lower_n,
    output logic [5:0] driver_group_enable,
    output tpss_trig_t [5:0] driver_trigger
);

    // ==========================================
    // helpers
    // settings outside 1..10 are pulled into range so a bad write cannot stall the counters
    function automatic logic [3:0] clamp_setting(input logic [3:0] v);
        if (v == 4'h0) begin
            return 4'h1;
        end else if (v > 4'ha) begin
            return 4'ha;
        end else begin
            return v;
        end
    endfunction

    function automatic logic [5:0] one_hot_pos(input logic [2:0] p);
        logic [5:0] r;
        r = 6'h00;
        if (p < 3'h6) begin
            r[p] = 1'b1;
        end
        return r;
    endfunction

    // ==========================================
    // apb registers
    logic [31:0] ctrl;
    logic restart;
    logic wr_en;
    logic setup;
    logic addr_ok;
    logic [31:0] status_word;
    tpss_apb_rsp_t next_rsp;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign addr_ok = (paddr == `TPSS_ADDR_CTRL) || (paddr == `TPSS_ADDR_RESTART) ||
        (paddr == `TPSS_ADDR_STATUS);

    always_comb begin
        next_rsp.ready = setup;
        next_rsp.slverr = setup && !addr_ok;
        next_rsp.rdata = 32'h00000000;
        if (setup && !pwrite) begin
            unique case (paddr)
                `TPSS_ADDR_CTRL: next_rsp.rdata = ctrl;
                `TPSS_ADDR_STATUS: next_rsp.rdata = status_word;
                default: next_rsp.rdata = 32'h00000000;
            endcase
        end
    end

    // no wait states: answer is registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= next_rsp.ready;
            pslverr <= next_rsp.slverr;
            prdata <= next_rsp.rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `TPSS_CTRL_RESET;
        end else if (wr_en && paddr == `TPSS_ADDR_CTRL) begin
            ctrl <= pwdata & `TPSS_CTRL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart <= 1'b0;
        end else begin
            restart <= wr_en && paddr == `TPSS_ADDR_RESTART && pwdata[0];
        end
    end

    tpss_mode_t mode;
    logic [2:0] manual_position_selector;
    logic timebase_source_selector;
    logic [3:0] on_time_selector;
    logic [3:0] rate_selector;

    assign mode = ctrl[`TPSS_CTRL_AUTO] ? TPSS_MODE_AUTO : TPSS_MODE_MANUAL;
    assign manual_position_selector = ctrl[`TPSS_CTRL_MANPOS_HI:`TPSS_CTRL_MANPOS_LO];
    assign timebase_source_selector = ctrl[`TPSS_CTRL_SRC_EXT];
    assign on_time_selector = clamp_setting(ctrl[`TPSS_CTRL_ONTIME_HI:`TPSS_CTRL_ONTIME_LO]);
    assign rate_selector = clamp_setting(ctrl[`TPSS_CTRL_RATE_HI:`TPSS_CTRL_RATE_LO]);

    // ==========================================
    // timebase and minute prescaler
    logic timebase_prev;
    logic timebase_now;
    logic timebase_tick;
    logic [`TPSS_PRESCALE_BITS-1:0] prescale;
    logic minute_tick;
    localparam logic [`TPSS_PRESCALE_BITS-1:0] PRESCALE_LAST =
        `TPSS_PRESCALE_BITS'(PRESCALE_DIV - 1);

    assign timebase_now = timebase_source_selector ? check_clock : line_60hz;
    assign timebase_tick = timebase_now && !timebase_prev;
    assign minute_tick = timebase_tick && (prescale == PRESCALE_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timebase_prev <= 1'b0;
        end else begin
            timebase_prev <= timebase_now;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= '0;
        end else if (restart) begin
            prescale <= '0;
        end else if (timebase_tick) begin
            prescale <= minute_tick ? '0 : prescale + 1'b1;
        end
    end

    // ==========================================
    // minute decade, tens counter and on-time flop
    logic [3:0] minutes;
    logic [3:0] tens;
    logic on_time_ff;
    logic minute_wrap;
    logic [3:0] minute_state;
    logic gated_enable;
    logic gated_prev;

    assign minute_wrap = minute_tick && (minutes == 4'(`TPSS_DECADE - 1));
    assign minute_state = minutes + 4'h1; // decoded states one through ten

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            minutes <= 4'h0;
        end else if (restart) begin
            minutes <= 4'h0;
        end else if (minute_tick) begin
            minutes <= minute_wrap ? 4'h0 : minutes + 4'h1;
        end
    end

    // set at minute zero wins over the clear, so a ten-minute on-time stays solid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_time_ff <= 1'b1;
        end else if (restart) begin
            on_time_ff <= 1'b1;
        end else if (minute_wrap) begin
            on_time_ff <= 1'b1;
        end else if (minute_tick && minute_state == on_time_selector) begin
            on_time_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tens <= 4'h0;
        end else if (restart) begin
            tens <= 4'h0;
        end else if (minute_wrap) begin
            tens <= (tens + 4'h1 == rate_selector) ? 4'h0 : tens + 4'h1;
        end
    end

    assign gated_enable = on_time_ff && (tens == 4'h0);

    // ==========================================
    // position counter
    logic [2:0] position;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gated_prev <= 1'b1;
        end else begin
            gated_prev <= restart ? 1'b1 : gated_enable;
        end
    end

    // advance on the end of each sample so the next sample lands on the next position
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            position <= 3'h0;
        end else if (restart) begin
            position <= 3'h0;
        end else if (gated_prev && !gated_enable) begin
            position <= (position == 3'(`TPSS_POSITIONS - 1)) ? 3'h0 : position + 3'h1;
        end
    end

    // ==========================================
    // selects and bridge switch controls
    logic [5:0] next_select;

    always_comb begin
        if (mode == TPSS_MODE_MANUAL) begin
            next_select = one_hot_pos(manual_position_selector);
        end else begin
            next_select = one_hot_pos(position) & {6{gated_enable}};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            position_select <= 6'h00;
            driver_group_enable <= 6'h00;
        end else begin
            position_select <= next_select;
            driver_group_enable <= next_select;
        end
    end

    // controls are low-active: a low level turns the selected bridge switch on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bridge_switch_upper_n <= 6'h3f;
            bridge_switch_lower_n <= 6'h3f;
        end else begin
            bridge_switch_upper_n <= ~next_select;
            bridge_switch_lower_n <= ~next_select;
        end
    end

    // ==========================================
    // comparator edges, half-cycle interlock
    tpss_trig_t comp_prev;
    tpss_trig_t comp_rise;
    tpss_trig_t fire;
    tpss_trig_t pulse;
    logic phase_prev;
    logic half_start;
    logic upper_heat_seen;
    logic upper_cool_seen;
    logic lower_heat_seen;
    logic lower_cool_seen;

    assign comp_rise = comparator & ~comp_prev;
    assign half_start = supply_phase_positive != phase_prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_prev <= '0;
            phase_prev <= 1'b0;
        end else begin
            comp_prev <= comparator;
            phase_prev <= supply_phase_positive;
        end
    end

    // heat only while its phase is negative; heat and cool exclude each other per half cycle
    always_comb begin
        fire.upper_heat = comp_rise.upper_heat && !supply_phase_positive &&
            !(upper_cool_seen && !half_start) && !comp_rise.upper_cool;
        fire.lower_heat = comp_rise.lower_heat && !supply_phase_positive &&
            !(lower_cool_seen && !half_start) && !comp_rise.lower_cool;
        fire.upper_cool = comp_rise.upper_cool &&
            !(upper_heat_seen && !half_start);
        fire.lower_cool = comp_rise.lower_cool &&
            !(lower_heat_seen && !half_start);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_heat_seen <= 1'b0;
            upper_cool_seen <= 1'b0;
            lower_heat_seen <= 1'b0;
            lower_cool_seen <= 1'b0;
        end else begin
            upper_heat_seen <= fire.upper_heat || (upper_heat_seen && !half_start);
            upper_cool_seen <= fire.upper_cool || (upper_cool_seen && !half_start);
            lower_heat_seen <= fire.lower_heat || (lower_heat_seen && !half_start);
            lower_cool_seen <= fire.lower_cool || (lower_cool_seen && !half_start);
        end
    end

    tpss_pulse_stretch #(
        .WIDTH_CYCLES(TRIG_CYCLES),
        .CNT_BITS(8)
    ) u_stretch (
        .pclk(pclk),
        .presetn(presetn),
        .fire(fire),
        .pulse(pulse)
    );

    // ==========================================
    // steering into the 24 drivers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            driver_trigger <= '0;
        end else begin
            for (int g = 0; g < `TPSS_POSITIONS; g++) begin
                driver_trigger[g] <= driver_group_enable[g] ? pulse : '0;
            end
        end
    end

    // ==========================================
    // status
    always_comb begin
        status_word = 32'h00000000;
        status_word[`TPSS_STAT_SEL_HI:`TPSS_STAT_SEL_LO] = position_select;
        status_word[`TPSS_STAT_GATE] = gated_enable;
        status_word[`TPSS_STAT_POS_HI:`TPSS_STAT_POS_LO] = position;
        status_word[`TPSS_STAT_MIN_HI:`TPSS_STAT_MIN_LO] = minutes;
        status_word[`TPSS_STAT_TENS_HI:`TPSS_STAT_TENS_LO] = tens;
        status_word[`TPSS_STAT_ONFF] = on_time_ff;
    end

endmodule

// ---- tb/tpss_sequencer_checker.sv ----
// concurrent checks on the sequencer ports: selects, bridge controls, triggers, apb answer
// assumes one pclk domain and a bind onto every sequencer instance
`timescale 1ns/1ps
module tpss_sequencer_checker
    import tpss_pkg::*;
#(
    parameter int TRIG_CYCLES = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire tpss_trig_t comparator,
    input wire logic supply_phase_positive,
    input wire logic [5:0] position_select,
    input wire logic [5:0] bridge_switch_upper_n,
    input wire logic [5:0] bridge_switch_lower_n,
    input wire logic [5:0] driver_group_enable,
    input wire tpss_trig_t [5:0] driver_trigger
);
    logic [1:0] h, c, h_d, c_d, hs, cs, hr, cr, hp, cp;
    logic ph1, ph2, ph3;
    int cnt;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ====
    // helpers: trigger lines over all groups, half cycle seen two cycles late
    always_comb begin
        h = 2'h0;
        c = 2'h0;
        for (int g = 0; g < 6; g++) begin
            h |= {driver_trigger[g].upper_heat, driver_trigger[g].lower_heat};
            c |= {driver_trigger[g].upper_cool, driver_trigger[g].lower_cool};
        end
    end
    assign hr = h & ~h_d;
    assign cr = c & ~c_d;
    assign hp = (ph2 == ph3) ? hs : 2'h0;
    assign cp = (ph2 == ph3) ? cs : 2'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
        end else begin
            cnt <= c[1] ? cnt + 1 : 0;
        end
    end
    // triggers trail the comparator by two cycles, so the phase is delayed alike
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {ph1, ph2, ph3, h_d, c_d, hs, cs} <= '0;
        end else begin
            {ph1, ph2, ph3} <= {supply_phase_positive, ph1, ph2};
            {h_d, c_d} <= {h, c};
            hs <= (ph2 != ph3) ? hr : (hs | hr);
            cs <= (ph2 != ph3) ? cr : (cs | cr);
        end
    end
    // ====
    // assertions
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_apb_answer: assert property (s_setup |=> s_answer)
        else $error("apb answer not one cycle after setup");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    a_bridge_inverse: assert property ((bridge_switch_upper_n == ~position_select)
        && (bridge_switch_lower_n == ~position_select)) else $error("bridge control not inverse");
    a_group_enable: assert property (driver_group_enable == position_select)
        else $error("group enable differs from select");
    a_one_select: assert property ($onehot0(position_select))
        else $error("more than one select");
    a_idle_drivers: assert property (position_select == 6'h00 && $past(position_select) == 6'h00
        && $past(position_select, 2) == 6'h00 |-> driver_trigger == '0) else $error("idle drive");
    a_cool_start: assert property ($rose(c[1]) && $stable(position_select) |->
        $past(comparator.upper_cool, 2) && !$past(comparator.upper_cool, 3))
        else $error("cool trigger without comparator edge");
    a_cool_width: assert property ($fell(c[1]) && $stable(position_select) |->
        cnt == TRIG_CYCLES) else $error("trigger width wrong");
    a_heat_phase: assert property ($rose(h[1]) && $stable(position_select) |->
        !$past(supply_phase_positive, 2)) else $error("heat trigger in positive phase");
    a_heat_cool: assert property (((hr & (cp | cr)) | (cr & hp)) == 2'h0)
        else $error("heat and cool in one half cycle");
endmodule

bind tpss_sequencer tpss_sequencer_checker #(.TRIG_CYCLES(TRIG_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .comparator(comparator), .supply_phase_positive(supply_phase_positive),
    .position_select(position_select), .bridge_switch_upper_n(bridge_switch_upper_n),
    .bridge_switch_lower_n(bridge_switch_lower_n), .driver_group_enable(driver_group_enable),
    .driver_trigger(driver_trigger));

// ---- tb/tpss_power_stage.sv ----
// model of the comparators, supply phase and commutating switches around the sequencer
// assumes one pclk domain; comparator levels follow the bench's requests a cycle later
`timescale 1ns/1ps
module tpss_power_stage
    import tpss_pkg::*;
#(
    parameter int HALF_CYCLES = 40
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire tpss_trig_t want,
    input wire tpss_trig_t [5:0] driver_trigger,
    input wire logic [5:0] bridge_switch_upper_n,
    output tpss_trig_t comparator,
    output logic supply_phase_positive,
    output logic [5:0] sensor_on,
    output logic short_fault
);
    int half_cnt;
    logic [1:0] heat_on, cool_on, hh, ch;
    always_comb begin
        hh = 2'h0;
        ch = 2'h0;
        for (int g = 0; g < 6; g++) begin
            hh |= {driver_trigger[g].upper_heat, driver_trigger[g].lower_heat};
            ch |= {driver_trigger[g].upper_cool, driver_trigger[g].lower_cool};
        end
    end
    // ====
    // inverter half cycles and comparator outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_cnt <= 0;
            supply_phase_positive <= 1'h0;
            comparator <= '0;
        end else begin
            half_cnt <= (half_cnt == HALF_CYCLES - 1) ? 0 : half_cnt + 1;
            if (half_cnt == HALF_CYCLES - 1) supply_phase_positive <= ~supply_phase_positive;
            comparator <= want;
        end
    end
    // ====
    // switches latch on a trigger and drop out when the half cycle ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {heat_on, cool_on, short_fault} <= '0;
        end else begin
            cool_on <= (half_cnt == HALF_CYCLES - 1) ? 2'h0 : (cool_on | ch);
            heat_on <= (half_cnt == HALF_CYCLES - 1) ? 2'h0
                : (heat_on | (supply_phase_positive ? 2'h0 : hh));
            short_fault <= short_fault | (|(heat_on & cool_on));
        end
    end
    // a sensor joins its bridge while its control is held low
    assign sensor_on = ~bridge_switch_upper_n;
endmodule

// ---- tb/tb.sv ----
// bench for the sequencer: apb master, timebase, manual, trigger and automatic runs
// assumes the power stage model supplies the comparators and the supply phase
`timescale 1ns/1ps
`include "tpss_map.svh"
module tb;
    import tpss_pkg::*;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, ph, short_fault, use_line = 1'h1, tb_line, chk_clk;
    logic [5:0] sel, bru, brl, gen, son, e;
    tpss_trig_t want = '0, comp;
    tpss_trig_t [5:0] trig, exp_t;
    logic [32:0] q[$];
    int n_fail = 0, cmp_count = 0, seed = 39, div = 0, t0, r;
    logic [31:0] cfg [2] = '{32'h00002301, 32'h00001111};
    int len [2] = '{96, 32}, per [2] = '{640, 320};
    initial forever #5 pclk = ~pclk;
    // timebase square wave of 8 cycles, steered to one source
    always @(posedge pclk) div <= div + 1;
    assign tb_line = div[2] & use_line;
    assign chk_clk = div[2] & ~use_line;
    tpss_sequencer #(.PRESCALE_DIV(4), .TRIG_CYCLES(3)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .line_60hz(tb_line),
        .check_clock(chk_clk), .comparator(comp), .supply_phase_positive(ph),
        .position_select(sel), .bridge_switch_upper_n(bru), .bridge_switch_lower_n(brl),
        .driver_group_enable(gen), .driver_trigger(trig));
    tpss_power_stage u_stage (.pclk(pclk), .presetn(presetn), .want(want),
        .driver_trigger(trig), .bridge_switch_upper_n(bru), .comparator(comp),
        .supply_phase_positive(ph), .sensor_on(son), .short_fault(short_fault));
    // ====
    // tasks
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] x);
        int n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
        if (!w) q.push_back(x);
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1 && n++ < 20);
        if (n > 20) n_fail++;
        {psel, penable} <= 2'h0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic wt_sel(input logic [5:0] v);
        int n = 0;
        while (sel !== v && n++ < 2000) @(posedge pclk);
        if (n > 2000) n_fail++;
    endtask
    task automatic half(input logic p);
        repeat (90) if (ph === p) @(posedge pclk);
        repeat (90) if (ph !== p) @(posedge pclk);
    endtask
    task automatic fire(input int k);
        @(posedge pclk);
        want <= tpss_trig_t'(4'h8 >> k);
        @(posedge pclk);
        want <= '0;
    endtask
    // reads are matched in order as they appear on the bus
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'h1 && !pwrite) chk({pslverr, prdata}, q.pop_front());
    end
    initial begin
        #300000;
        n_fail++;
        report_and_stop();
    end
    // ====
    // main sequence
    initial begin
        wt(16);
        chk({bru, brl, sel, trig}, {6'h3f, 6'h3f, 6'h00, 24'h0});
        presetn <= 1'h1;
        wt(2);
        chk(sel, 6'h01);
        apb(1'h0, `TPSS_ADDR_CTRL, 32'h0, {1'h0, `TPSS_CTRL_RESET});
        apb(1'h0, 12'h00c, 32'h0, {1'h1, 32'h0});
        for (int p = 0; p < 7; p++) begin
            apb(1'h1, `TPSS_ADDR_CTRL, 32'h1100 | (p << 1), '0);
            wt(2);
            e = (p < 6) ? 6'h01 << p : 6'h00;
            chk({sel, gen, son}, {3{e}});
            chk({bru, brl}, {2{~e}});
            r = $random(seed);
            for (int k = 0; k < 4; k++) begin
                half(1'h0);
                fire((k + r) & 3);
                wt(3);
                exp_t = '0;
                if (p < 6) exp_t[p] = tpss_trig_t'(4'h8 >> ((k + r) & 3));
                chk(trig, exp_t);
                wt(3);
                chk(trig, '0);
            end
        end
        apb(1'h1, `TPSS_ADDR_CTRL, 32'h1102, '0);
        half(1'h0);
        fire(2);
        wt(6);
        fire(0);
        wt(3);
        chk(trig, '0);
        half(1'h1);
        fire(0);
        wt(3);
        chk(trig, '0);
        half(1'h0);
        fire(0);
        wt(3);
        exp_t = 24'h000080;
        chk(trig, exp_t);
        for (int i = 0; i < 2; i++) begin
            use_line <= ~cfg[i][4];
            apb(1'h1, `TPSS_ADDR_CTRL, cfg[i], '0);
            apb(1'h1, `TPSS_ADDR_RESTART, 32'h1, '0);
            wt(2);
            chk(sel, 6'h01);
            wt_sel(6'h02);
            for (int p = 2; p < 8; p++) begin
                t0 = div;
                wt_sel(6'h00);
                chk(div - t0, len[i]);
                wt_sel(6'h01 << (p % 6));
                chk(div - t0, per[i]);
            end
        end
        chk(short_fault, 1'h0);
        report_and_stop();
    end
endmodule
